// ==== src/ssfc_top.sv ====
`timescale 1ns/1ns
`default_nettype none
module ssfc_top #(
  parameter int unsigned OL_FILTER_CYC = ssfc_pkg::OL_FILTER_CYC,
  parameter int unsigned SHORT_CYC = ssfc_pkg::SHORT_CYC
) (
  input wire logic clk, // 50 MHz block clock
  input wire logic resetn, // async reset, active low
  input wire logic sclk, // serial clock pin
  input wire logic cs_n, // chip select pin, active low
  input wire logic si, // serial data in
  output logic so, // serial data out
  output logic so_oe, // so driven while high
  input wire logic [15:0] open_load_cmp, // per-output open-load comparator
  input wire logic [15:0] vds_high, // per-output drain-voltage comparator
  input wire logic [15:0] in_current_limit, // per-output current limit flag
  input wire logic [15:0] thermal_flag, // per-output overtemperature flag
  input wire logic overvoltage, // battery overvoltage flag
  input wire logic output_driver_supply_uv, // driver supply undervoltage
  input wire logic main_battery_supply_uv, // battery undervoltage
  input wire logic sleep, // sleep entry
  output logic [15:0] low_side_outputs, // output switch gates
  output logic [15:0] ol_pulldown_en, // open-load pulldown enables
  output logic any_fault // mirror of status bit 23
);
  localparam int unsigned OLW = $clog2(OL_FILTER_CYC + 1);
  localparam int unsigned SCW = $clog2(SHORT_CYC + 1);
  localparam int unsigned SYW = 3 + 4 * ssfc_pkg::NUM_OUT + 4;

  generate
    if (OL_FILTER_CYC < 1 || SHORT_CYC < 1) begin : g_bad_cyc
      $error("ssfc_top timer counts must be at least one");
    end
  endgenerate

  function automatic logic is_cmd(input logic [23:0] w, input logic [5:0] code);
    is_cmd = (w[ssfc_pkg::CMD_HI:ssfc_pkg::CMD_LO] == code);
  endfunction : is_cmd

  // pins async to clk; select enters inverted so the reset value reads idle
  logic [SYW-1:0] sy;
  logic s_sclk, s_cs_sel, s_si, s_ov, s_drv_uv, s_bat_uv, s_sleep;
  logic [15:0] s_olc, s_vds, s_ilim, s_th;
  ssfc_sync #(.W(SYW)) u_sync (
    .clk(clk),
    .resetn(resetn),
    .d({sclk, ~cs_n, si, open_load_cmp, vds_high, in_current_limit, thermal_flag,
        overvoltage, output_driver_supply_uv, main_battery_supply_uv, sleep}),
    .q(sy)
  );
  assign {s_sclk, s_cs_sel, s_si, s_olc, s_vds, s_ilim, s_th,
          s_ov, s_drv_uv, s_bat_uv, s_sleep} = sy;

  // link state
  ssfc_pkg::ssfc_lnk_t st_q, st_d;
  logic sclk_q, cs_q, so_q, so_d, oe_q, oe_d, exec, capture;
  logic [23:0] sr_q, sr_d, status;
  logic sclk_rise, sclk_fall, cs_fall, cs_rise;
  // control registers
  logic [15:0] on_q, on_d, olen_q, olen_d, fssd_q, fssd_d;
  logic th_retry_q, th_retry_d, ov_retry_q, ov_retry_d, ctl_rst, onoff_wr;
  // protection and faults
  logic [15:0] th_off_q, th_off_d, sc_off_q, sc_off_d, out_q, out_d;
  logic [15:0] fault_q, fault_d, ol_det, sc_trip, cond;
  logic ov_off_q, ov_off_d, ov_flag_q, ov_flag_d, any_q, any_d, ol_done;
  logic [OLW-1:0] ol_cnt_q, ol_cnt_d;

  assign sclk_rise = s_sclk & ~sclk_q;
  assign sclk_fall = ~s_sclk & sclk_q;
  assign cs_fall = cs_q & s_cs_sel;
  assign cs_rise = ~cs_q & ~s_cs_sel;
  assign status = {any_q, ov_flag_q, ssfc_pkg::STATUS_PAD, fault_q}; // R19 R3
  assign capture = (st_q == ssfc_pkg::LNK_IDLE) & cs_fall;
  assign exec = (st_q == ssfc_pkg::LNK_ACTIVE) & cs_rise;

  always_comb begin
    st_d = st_q;
    sr_d = sr_q;
    so_d = so_q;
    unique case (st_q)
      ssfc_pkg::LNK_IDLE: begin
        if (cs_fall) begin
          st_d = ssfc_pkg::LNK_ACTIVE;
          sr_d = status; // R21
          so_d = status[ssfc_pkg::ANY_FAULT_BIT]; // R19
        end
      end
      ssfc_pkg::LNK_ACTIVE: begin
        // in on falling edge, out on rising; 48 clocks echo the first word
        if (sclk_fall) begin
          sr_d = {sr_q[22:0], s_si}; // R4 R20
        end
        if (sclk_rise) begin
          so_d = sr_q[23]; // R4 R20 R19
        end
        if (cs_rise) begin
          st_d = ssfc_pkg::LNK_IDLE;
          so_d = 1'b0;
        end
      end
      default: begin
        st_d = ssfc_pkg::LNK_IDLE;
        so_d = 1'b0;
      end
    endcase
    if (s_bat_uv) begin
      st_d = ssfc_pkg::LNK_IDLE; // R17
      so_d = 1'b0;
    end
    oe_d = (st_d == ssfc_pkg::LNK_ACTIVE);
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= ssfc_pkg::LNK_IDLE;
      sr_q <= '0;
      so_q <= 1'b0;
      oe_q <= 1'b0;
      sclk_q <= 1'b0;
      cs_q <= 1'b1;
    end else begin
      st_q <= st_d;
      sr_q <= sr_d;
      so_q <= so_d;
      oe_q <= oe_d;
      sclk_q <= s_sclk;
      cs_q <= ~s_cs_sel;
    end
  end

  // command execution at chip-select rise; undervoltage wins over any command
  assign ctl_rst = s_drv_uv | s_bat_uv | (exec & is_cmd(sr_q, ssfc_pkg::CMD_RESET));
  assign onoff_wr = exec & is_cmd(sr_q, ssfc_pkg::CMD_ONOFF);

  always_comb begin
    on_d = on_q;
    olen_d = olen_q;
    fssd_d = fssd_q;
    th_retry_d = th_retry_q;
    ov_retry_d = ov_retry_q;
    if (onoff_wr) begin
      on_d = sr_q[15:0]; // R5 R8 R2
    end
    if (exec && is_cmd(sr_q, ssfc_pkg::CMD_OL_EN)) begin
      olen_d = sr_q[15:0]; // R10
    end
    if (exec && is_cmd(sr_q, ssfc_pkg::CMD_FSSD)) begin
      fssd_d = sr_q[15:0];
    end
    if (exec && is_cmd(sr_q, ssfc_pkg::CMD_RETRY)) begin
      th_retry_d = sr_q[ssfc_pkg::THERM_RETRY_BIT];
      ov_retry_d = sr_q[ssfc_pkg::OV_RETRY_BIT];
    end
    if (s_sleep) begin
      olen_d = ssfc_pkg::OL_EN_RST; // R10
    end
    if (ctl_rst) begin
      on_d = ssfc_pkg::ONOFF_RST; // R16 R17
      olen_d = ssfc_pkg::OL_EN_RST;
      fssd_d = ssfc_pkg::FSSD_RST;
      th_retry_d = ssfc_pkg::THERM_RETRY_RST;
      ov_retry_d = ssfc_pkg::OV_RETRY_RST;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      on_q <= ssfc_pkg::ONOFF_RST;
      olen_q <= ssfc_pkg::OL_EN_RST;
      fssd_q <= ssfc_pkg::FSSD_RST;
      th_retry_q <= ssfc_pkg::THERM_RETRY_RST;
      ov_retry_q <= ssfc_pkg::OV_RETRY_RST;
    end else begin
      on_q <= on_d;
      olen_q <= olen_d;
      fssd_q <= fssd_d;
      th_retry_q <= th_retry_d;
      ov_retry_q <= ov_retry_d;
    end
  end

  // per-output drain-high timers, only armed with fast shutdown enabled
  genvar gi;
  generate
    for (gi = 0; gi < ssfc_pkg::NUM_OUT; gi++) begin : g_short
      logic [SCW-1:0] cnt_q, cnt_d;
      always_comb begin
        cnt_d = '0;
        if (!fssd_q[gi] && s_vds[gi] && s_ilim[gi] && out_q[gi]) begin
          cnt_d = (cnt_q == SCW'(SHORT_CYC)) ? cnt_q : cnt_q + SCW'(1); // R13
        end
      end
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          cnt_q <= '0;
        end else begin
          cnt_q <= cnt_d;
        end
      end
      assign sc_trip[gi] = (cnt_q == SCW'(SHORT_CYC)); // R13
    end
  endgenerate

  assign ol_done = (ol_cnt_q == OLW'(OL_FILTER_CYC));
  // comparator ignored until filter expires; only outputs commanded off
  assign ol_det = ~on_q & olen_q & s_olc & {16{ol_done}}; // R9 R11
  assign cond = ol_det | sc_trip | s_th | (s_ilim & out_q); // R3 R15

  always_comb begin
    ol_cnt_d = ol_done ? ol_cnt_q : ol_cnt_q + OLW'(1);
    if (exec) begin
      ol_cnt_d = '0; // R11
    end
    th_off_d = s_th | (th_off_q & on_q & ~{16{th_retry_q}}); // R14 R18 R22
    sc_off_d = sc_trip | (sc_off_q & on_q); // R13
    ov_off_d = s_ov | (ov_off_q & ~ov_retry_q & ~onoff_wr);
    out_d = on_q & ~th_off_q & ~sc_off_q & ~{16{ov_off_q}}; // R2 R14
    // set wins over the read clear
    fault_d = cond | (fault_q & ~{16{capture}}); // R12 R23
    ov_flag_d = s_ov | (ov_flag_q & ~capture); // R23
    any_d = (|cond) | s_ov | (any_q & ~capture); // R15 R23
    if (s_drv_uv || s_bat_uv) begin
      out_d = '0; // R16 R17
    end
    if (s_bat_uv) begin
      th_off_d = '0; // R17
      sc_off_d = '0;
      ov_off_d = 1'b0;
      fault_d = '0;
      ov_flag_d = 1'b0;
      any_d = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ol_cnt_q <= '0;
      th_off_q <= '0;
      sc_off_q <= '0;
      ov_off_q <= 1'b0;
      out_q <= '0;
      fault_q <= '0;
      ov_flag_q <= 1'b0;
      any_q <= 1'b0;
    end else begin
      ol_cnt_q <= ol_cnt_d;
      th_off_q <= th_off_d;
      sc_off_q <= sc_off_d;
      ov_off_q <= ov_off_d;
      out_q <= out_d;
      fault_q <= fault_d;
      ov_flag_q <= ov_flag_d;
      any_q <= any_d;
    end
  end

  assign so = so_q;
  assign so_oe = oe_q;
  assign low_side_outputs = out_q;
  assign ol_pulldown_en = olen_q;
  assign any_fault = any_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence q_exec_onoff;
    onoff_wr && !s_drv_uv && !s_bat_uv;
  endsequence
  property p_onoff_load;
    q_exec_onoff |=> (on_q == $past(sr_q[15:0]));
  endproperty
  a_onoff_load: assert property (p_onoff_load) else $error("on/off word not loaded"); // R5
  property p_status_load;
    capture && !s_bat_uv |=> (sr_q == $past(status)) && (so_q == $past(status[23])) && so_oe;
  endproperty
  a_status_load: assert property (p_status_load) else $error("status not loaded"); // R21
  property p_shift_in;
    (st_q == ssfc_pkg::LNK_ACTIVE) && sclk_fall && !s_bat_uv
      |=> (sr_q[0] == $past(s_si)) && (sr_q[23:1] == $past(sr_q[22:0]));
  endproperty
  a_shift_in: assert property (p_shift_in) else $error("shift register did not shift"); // R4
  property p_filter_restart;
    exec |=> (ol_cnt_q == '0) && (ol_det == '0);
  endproperty
  a_filter_restart: assert property (p_filter_restart) else $error("filter not restarted"); // R11
  property p_ol_latch;
    (ol_det != '0) && !s_bat_uv |=> ((fault_q & $past(ol_det)) == $past(ol_det));
  endproperty
  a_ol_latch: assert property (p_ol_latch) else $error("open load not latched"); // R12
  property p_drv_uv;
    s_drv_uv |=> (on_q == '0) && (fssd_q == ssfc_pkg::FSSD_RST) ##1 (low_side_outputs == '0);
  endproperty
  a_drv_uv: assert property (p_drv_uv) else $error("driver uv did not reset"); // R16
  property p_bat_uv;
    s_bat_uv |=> (fault_q == '0) && !any_fault && (on_q == '0) ##1 (low_side_outputs == '0);
  endproperty
  a_bat_uv: assert property (p_bat_uv) else $error("battery uv did not reset"); // R17
  property p_thermal_off;
    (s_th != '0) |-> ##2 ((low_side_outputs & $past(s_th, 2)) == '0);
  endproperty
  a_thermal_off: assert property (p_thermal_off) else $error("hot output still on"); // R14
  property p_any_fault;
    ((cond != '0) || s_ov) && !s_bat_uv |=> any_fault;
  endproperty
  a_any_fault: assert property (p_any_fault) else $error("any-fault not set"); // R15
  property p_no_retry;
    !th_retry_q && (th_off_q & on_q) != '0 && !ctl_rst && !onoff_wr && !s_bat_uv
      |=> ((th_off_q & $past(th_off_q & on_q)) == $past(th_off_q & on_q));
  endproperty
  a_no_retry: assert property (p_no_retry) else $error("output retried with retry off"); // R22
  property p_sleep;
    s_sleep |=> (ol_pulldown_en == '0);
  endproperty
  a_sleep: assert property (p_sleep) else $error("pulldowns not cleared"); // R10
endmodule : ssfc_top
`default_nettype wire

// ==== src/ssfc_pkg.sv ====
// What this block does
// [R1] host keeps serial clock at most 6 MHz; the bench host clocks it at 6.25 MHz (8 clocks of 20 ns per bit)
// [R2] control bit zero off, one on
// [R3] status reports faulted outputs as one
// [R4] shift register passes data while selected
// [R5] chip-select rise loads shift register to outputs
// [R6] host clocks exactly 24 bits per device
// [R7] host checks 48-bit echo after reset
// [R8] last 24 bits execute at chip-select rise
// [R9] open load judged only while output off
// [R10] pulldowns cleared at reset, sleep, command
// [R11] chip-select rise restarts open-load filter timer
// [R12] open-load fault stays latched until read
// [R13] drain-high in current limit 450us trips off
// [R14] thermal flag switches off only that output
// [R15] protection events set any-fault bit 23
// [R16] driver-supply undervoltage resets controls, outputs off
// [R17] battery undervoltage resets device, outputs off
// [R18] cooled output obeys thermal retry bit
// [R19] status word layout, sent msb first
// [R20] sample on falling, shift on rising edge
// [R21] chip-select fall loads status into shifter
// [R22] retry bit zero stays off, one retries
// [R23] read clears latched flags once condition gone
`default_nettype none
package ssfc_pkg;
  localparam int unsigned NUM_OUT = 16;
  localparam int unsigned FRAME_BITS = 24;
  localparam int unsigned CLK_MHZ = 50;
  // link limit for the host, mhz
  localparam int unsigned SCLK_MAX_MHZ = 6;
  // open-load filter, least time, ns
  localparam int unsigned OL_FILTER_NS = 100000;
  // fast short shutdown delay, ns
  localparam int unsigned SHORT_NS = 450000;
  localparam int unsigned OL_FILTER_CYC = (OL_FILTER_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned SHORT_CYC = (SHORT_NS * CLK_MHZ + 999) / 1000;
  // status word bit positions
  localparam int unsigned ANY_FAULT_BIT = 23;
  localparam int unsigned OV_FAULT_BIT = 22;
  // command field and retry bits
  localparam int unsigned CMD_HI = 23;
  localparam int unsigned CMD_LO = 18;
  localparam int unsigned THERM_RETRY_BIT = 17;
  localparam int unsigned OV_RETRY_BIT = 16;
  localparam logic [5:0] CMD_ONOFF = 6'h00;
  localparam logic [5:0] CMD_OL_EN = 6'h01;
  localparam logic [5:0] CMD_RETRY = 6'h02;
  localparam logic [5:0] CMD_FSSD = 6'h03;
  localparam logic [5:0] CMD_RESET = 6'h06;
  // reset values of control registers, then the status pad bits
  localparam logic [15:0] ONOFF_RST = 16'h0000;
  localparam logic [15:0] OL_EN_RST = 16'h0000;
  localparam logic [15:0] FSSD_RST = 16'hFFFF;
  localparam logic THERM_RETRY_RST = 1'b0;
  localparam logic OV_RETRY_RST = 1'b0;
  localparam logic [5:0] STATUS_PAD = 6'h00;
  typedef enum logic [1:0] {
    LNK_IDLE = 2'b01,
    LNK_ACTIVE = 2'b10
  } ssfc_lnk_t;
endpackage : ssfc_pkg
`default_nettype wire

// ==== src/ssfc_sync.sv ====
`timescale 1ns/1ns
`default_nettype none
module ssfc_sync #(
  parameter int unsigned W = 1
) (
  input wire logic clk, // block clock
  input wire logic resetn, // async reset, active low
  input wire logic [W-1:0] d, // asynchronous inputs
  output logic [W-1:0] q // synchronised copies
);
  logic [W-1:0] meta_q;
  generate
    if (W < 1) begin : g_bad_w
      $error("ssfc_sync width must be at least one");
    end
  endgenerate
  // first stage is read only by the second
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule : ssfc_sync
`default_nettype wire

// ==== bench/ssfc_host.sv ====
`timescale 1ns/1ns
`default_nettype none
module ssfc_host (
  input wire logic clk, // paces the link
  output var logic sclk, // serial clock, idles low
  output var logic cs_n, // chip select, active low
  output var logic si, // serial data to device
  input wire logic so // serial data from device
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  // caller picks 24 bits per device in the chain
  task automatic xfer(input int n, input logic [47:0] tx, output logic [47:0] rx);
    rx = '0;
    cs_n = 1'b0;
    step(8);
    for (int i = n - 1; i >= 0; i--) begin
      step(2);
      // si moves mid-low so the synced fall never races it
      si = tx[i];
      step(2);
      sclk = 1'b1;
      step(4);
      // so moved on the rise; read it just before the fall
      rx = {rx[46:0], so};
      sclk = 1'b0;
    end
    step(4);
    cs_n = 1'b1;
    // released line must not keep its last value
    si = ~si;
    step(4);
  endtask : xfer
endmodule : ssfc_host
`default_nettype wire

// ==== bench/tb_ssfc_top.sv ====
`timescale 1ns/1ns
`default_nettype none
module tb_ssfc_top;
  localparam int unsigned OLC = 20;
  localparam int unsigned SHC = 30;
  logic clk, resetn, sclk, cs_n, si, so, so_oe, ovv, dsuv, bsuv, sleep, any_fault;
  logic [15:0] olc, vds, icl, thf, outs, pden;
  logic [47:0] rx;
  int n_fail = 0;
  int checked = 0;
  logic oe_hi = 1'b0;
  ssfc_top #(.OL_FILTER_CYC(OLC), .SHORT_CYC(SHC)) ssfc_top_inst (
    .clk(clk), .resetn(resetn), .sclk(sclk), .cs_n(cs_n), .si(si), .so(so),
    .so_oe(so_oe), .open_load_cmp(olc), .vds_high(vds), .in_current_limit(icl),
    .thermal_flag(thf), .overvoltage(ovv), .output_driver_supply_uv(dsuv),
    .main_battery_supply_uv(bsuv), .sleep(sleep), .low_side_outputs(outs),
    .ol_pulldown_en(pden), .any_fault(any_fault)
  );
  ssfc_host ssfc_host_inst (.clk(clk), .sclk(sclk), .cs_n(cs_n), .si(si), .so(so));
  always #10 clk = ~clk;
  // remembers that so was driven at some point of a frame
  always @(posedge clk) begin
    if (so_oe) begin
      oe_hi <= 1'b1;
    end
  end
  task automatic wrap_up;
    if (n_fail == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : wrap_up
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic cmd(input logic [5:0] code, input logic [1:0] rb, input logic [15:0] b);
    ssfc_host_inst.xfer(24, {24'h000000, code, rb, b}, rx);
    cyc(4);
  endtask : cmd
  task automatic t_echo;
    ssfc_host_inst.xfer(48, {24'h5A3C96, ssfc_pkg::CMD_ONOFF, 2'b00, 16'hA5C3}, rx);
    chk(rx[47:24], 24'h000000);
    chk(rx[23:0], 24'h5A3C96);
    chk({21'h000000, oe_hi, so_oe, so}, 24'h000004);
    cyc(2);
    chk({8'h00, outs}, 24'h00A5C3);
    cmd(ssfc_pkg::CMD_ONOFF, 2'b00, 16'h0000);
    chk({8'h00, outs}, 24'h000000);
  endtask : t_echo
  task automatic t_ol;
    cmd(ssfc_pkg::CMD_OL_EN, 2'b00, 16'h0010);
    chk({8'h00, pden}, 24'h000010);
    olc = 16'h0010;
    // code 3F is unlisted, so these frames only read status and restart the open-load filter timer
    cmd(6'h3F, 2'b00, 16'h0000);
    chk(rx[23:0], 24'h000000);
    cyc(OLC + 10);
    cmd(6'h3F, 2'b00, 16'h0000);
    chk({8'h00, rx[15:0]}, 24'h000010);
    olc = 16'h0000;
    cyc(4);
    cmd(6'h3F, 2'b00, 16'h0000);
    chk({8'h00, rx[15:0]}, 24'h000010);
    cmd(6'h3F, 2'b00, 16'h0000);
    chk({8'h00, rx[15:0]}, 24'h000000);
    sleep = 1'b1;
    cyc(6);
    chk({8'h00, pden}, 24'h000000);
    sleep = 1'b0;
  endtask : t_ol
  task automatic t_therm;
    cmd(ssfc_pkg::CMD_RETRY, 2'b10, 16'h0000);
    cmd(ssfc_pkg::CMD_ONOFF, 2'b00, 16'h0006);
    thf = 16'h0004;
    cyc(6);
    chk({8'h00, outs}, 24'h000002);
    chk({23'h000000, any_fault}, 24'h000001);
    thf = 16'h0000;
    cyc(6);
    chk({8'h00, outs}, 24'h000006);
    cmd(ssfc_pkg::CMD_RETRY, 2'b00, 16'h0000);
    thf = 16'h0002;
    cyc(6);
    thf = 16'h0000;
    cyc(6);
    chk({8'h00, outs}, 24'h000004);
    cmd(6'h3F, 2'b00, 16'h0000);
    chk(rx[23:0], 24'h800002);
  endtask : t_therm
  task automatic t_short;
    cmd(ssfc_pkg::CMD_FSSD, 2'b00, 16'hFFFE);
    cmd(ssfc_pkg::CMD_ONOFF, 2'b00, 16'h0001);
    vds = 16'h0001;
    icl = 16'h0001;
    cyc(SHC - 10);
    chk({8'h00, outs}, 24'h000001);
    cyc(20);
    chk({8'h00, outs}, 24'h000000);
    chk({23'h000000, any_fault}, 24'h000001);
    vds = 16'h0000;
    icl = 16'h0000;
    cmd(6'h3F, 2'b00, 16'h0000);
    chk(rx[23:0], 24'h800001);
  endtask : t_short
  task automatic t_uv;
    cmd(ssfc_pkg::CMD_ONOFF, 2'b00, 16'hFFFF);
    cmd(ssfc_pkg::CMD_OL_EN, 2'b00, 16'h00FF);
    dsuv = 1'b1;
    cyc(6);
    chk({8'h00, pden}, 24'h000000);
    chk({8'h00, outs}, 24'h000000);
    dsuv = 1'b0;
    cyc(4);
    chk({8'h00, pden}, 24'h000000);
    chk({8'h00, outs}, 24'h000000);
    cmd(ssfc_pkg::CMD_ONOFF, 2'b00, 16'h00F0);
    bsuv = 1'b1;
    cyc(6);
    chk({8'h00, outs}, 24'h000000);
    bsuv = 1'b0;
    cyc(4);
    cmd(6'h3F, 2'b00, 16'h0000);
    chk(rx[23:0], 24'h000000);
  endtask : t_uv
  task automatic t_ov;
    cmd(ssfc_pkg::CMD_ONOFF, 2'b00, 16'h0003);
    ovv = 1'b1;
    cyc(6);
    chk({8'h00, outs}, 24'h000000);
    chk({23'h000000, any_fault}, 24'h000001);
    ovv = 1'b0;
    cyc(6);
    // overvoltage retry is off after the battery reset
    chk({8'h00, outs}, 24'h000000);
    cmd(6'h3F, 2'b00, 16'h0000);
    chk(rx[23:0], 24'hC00000);
    cmd(ssfc_pkg::CMD_ONOFF, 2'b00, 16'h0003);
    chk({8'h00, outs}, 24'h000003);
    cmd(ssfc_pkg::CMD_RETRY, 2'b01, 16'h0000);
    ovv = 1'b1;
    cyc(6);
    chk({8'h00, outs}, 24'h000000);
    ovv = 1'b0;
    cyc(6);
    chk({8'h00, outs}, 24'h000003);
  endtask : t_ov
  initial begin
    clk = 1'b0;
    resetn = 1'b0;
    {olc, vds, icl, thf} = '0;
    {ovv, dsuv, bsuv, sleep} = '0;
    repeat (6) @(posedge clk);
    #1;
    resetn = 1'b1;
    cyc(4);
    t_echo;
    t_ol;
    t_therm;
    t_short;
    t_uv;
    t_ov;
    wrap_up;
  end
  // whole run is near 5000 cycles, so 1 ms means a hang
  initial begin
    #1000000;
    n_fail++;
    wrap_up;
  end
endmodule : tb_ssfc_top
`default_nettype wire
